//--- ocg_regs.svh
/*
 * constants of the half-bridge overcurrent guard: pin vector layout and
 * the trip-level lookup.
 * assumes it is included by its bare name before the package.
 */
`ifndef OCG_REGS_SVH
`define OCG_REGS_SVH

// ****************************************
// pin vector layout (synchronised inputs)
// ****************************************
`define OCG_NUM_BRIDGES 4
`define OCG_PIN_W 11
`define OCG_PIN_PWM 0
`define OCG_PIN_CLR 4
`define OCG_PIN_LAT 6
`define OCG_PIN_SHORT 7
`define OCG_PIN_RESET 11'h000

// ****************************************
// trip lookup: resistor in kohm, level in 0.1 A
// ****************************************
`define OCG_RES_22K 8'h16
`define OCG_RES_24K 8'h18
`define OCG_RES_27K 8'h1B
`define OCG_RES_30K 8'h1E
`define OCG_LVL_22K 8'h74
`define OCG_LVL_24K 8'h6B
`define OCG_LVL_27K 8'h61
`define OCG_LVL_30K 8'h58
`define OCG_LVL_36K 8'h4A
`define OCG_LVL_RESET 8'h4A

`endif

//--- ocg_pkg.sv
/*
 * types of the half-bridge overcurrent guard.
 * assumes ocg_regs.svh is on the include path.
 */
`include "ocg_regs.svh"

package ocg_pkg;

	// ****************************************
	// per-bridge protection state
	// ****************************************
	typedef enum logic [2:0] {
		OCG_RUN = 3'b001,
		OCG_LIM = 3'b010,
		OCG_SHUT = 3'b100
	} ocg_state_t;

	typedef struct packed {
		ocg_state_t state;
		logic pwm_prev;
		logic hs_gate;
		logic ls_gate;
		logic hiz;
	} ocg_bridge_st_t;

	typedef struct packed {
		logic [`OCG_PIN_W-1:0] s1;
		logic [`OCG_PIN_W-1:0] s2;
		logic [`OCG_PIN_W-1:0] s3;
		logic [`OCG_PIN_W-1:0] filt;
		logic [1:0] clr_prev;
		logic [7:0] trip;
		logic fault_n;
	} ocg_top_st_t;

endpackage : ocg_pkg

//--- ocg_bridge_if.sv
/*
 * carrier between the guard top and one half-bridge protection slice.
 * assumes the top drives the ctrl side and the slice the bridge side.
 */
`timescale 1ns/1ps

interface ocg_bridge_if;
	logic pwm;
	logic hs_oc;
	logic ls_oc;
	logic short_det;
	logic latched;
	logic clear_low;
	logic clear_rise;
	logic hs_gate;
	logic ls_gate;
	logic hiz;
	logic shut;

	modport bridge(
		input pwm, hs_oc, ls_oc, short_det, latched, clear_low, clear_rise,
		output hs_gate, ls_gate, hiz, shut
	);
	modport ctrl(
		output pwm, hs_oc, ls_oc, short_det, latched, clear_low, clear_rise,
		input hs_gate, ls_gate, hiz, shut
	);
endinterface : ocg_bridge_if

//--- ocg_bridge.sv
/*
 * protection state of one half-bridge: per-cycle limiting, latched shutdown.
 * assumes all inputs are already synchronous to clk.
 */
`timescale 1ns/1ps

module ocg_bridge
	import ocg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// link to top
	ocg_bridge_if.bridge bus
);

	ocg_bridge_st_t q;
	ocg_bridge_st_t d;
	logic rise;
	logic any_oc;
	logic on;
	logic shut_cause;

	assign rise = bus.pwm & ~q.pwm_prev;
	assign any_oc = bus.hs_oc | bus.ls_oc;
	// latched mode turns any overcurrent into a shutdown cause
	assign shut_cause = bus.short_det || (bus.latched && any_oc);

	always_comb begin
		d = q;
		on = 1'b0;
		if (clk_en) begin
			d.pwm_prev = bus.pwm;
			case (q.state)
				OCG_RUN: begin
					if (shut_cause) begin
						d.state = OCG_SHUT;
					end else if (any_oc) begin
						d.state = OCG_LIM;
					end
				end
				OCG_LIM: begin
					if (shut_cause) begin
						d.state = OCG_SHUT;
					end else if (rise && !any_oc) begin
						// only a new period releases; a static input stays off
						d.state = OCG_RUN;
					end
				end
				OCG_SHUT: begin
					// set wins: a cause still present keeps the latch
					if (bus.clear_rise && !shut_cause) begin
						d.state = OCG_RUN;
					end
				end
				default: begin
					d.state = OCG_RUN;
				end
			endcase
			// both switches off in limit and shutdown: output floats
			on = (d.state == OCG_RUN) && !bus.clear_low;
			d.hs_gate = on & bus.pwm;
			d.ls_gate = on & ~bus.pwm;
			d.hiz = ~on;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '{state: OCG_RUN, pwm_prev: 1'b0, hs_gate: 1'b0, ls_gate: 1'b0, hiz: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign bus.hs_gate = q.hs_gate;
	assign bus.ls_gate = q.ls_gate;
	assign bus.hiz = q.hiz;
	assign bus.shut = (q.state == OCG_SHUT);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_LIM_OFF: assert property (
		clk_en && !bus.latched && !bus.short_det && any_oc && q.state == OCG_RUN
		|=> q.hiz && !q.hs_gate && !q.ls_gate
	) else $error("limit did not switch off bridge");
	AST_HS_LIM: assert property (
		clk_en && !bus.latched && !bus.short_det && bus.hs_oc && q.state == OCG_RUN
		|=> q.state == OCG_LIM && !q.hs_gate
	) else $error("high side not limited");
	AST_LIM_HOLD: assert property (
		clk_en && q.state == OCG_LIM && !rise |=> q.state != OCG_RUN && q.hiz
	) else $error("limit released without new period");
	AST_SHORT: assert property (
		clk_en && bus.short_det && q.state != OCG_SHUT |=> q.state == OCG_SHUT && q.hiz
	) else $error("short did not latch shutdown");
	AST_LATCHED: assert property (
		clk_en && bus.latched && any_oc && q.state != OCG_SHUT |=> q.state == OCG_SHUT
	) else $error("latched mode did not shut down");
	AST_SHUT_HOLD: assert property (
		q.state == OCG_SHUT && !(clk_en && bus.clear_rise) |=> q.state == OCG_SHUT
	) else $error("shutdown left without clear");
	AST_CLEAR: assert property (
		clk_en && q.state == OCG_SHUT && bus.clear_rise && !shut_cause |=> q.state == OCG_RUN
	) else $error("clear edge did not release shutdown");
	AST_CLEAR_SET: assert property (
		clk_en && q.state == OCG_SHUT && shut_cause |=> q.state == OCG_SHUT
	) else $error("clear released a live fault");

	COV_LIM: cover property (q.state == OCG_RUN ##1 q.state == OCG_LIM ##[1:50] q.state == OCG_RUN);
	COV_SHUT: cover property (q.state == OCG_LIM ##1 q.state == OCG_SHUT);
	COV_RECOVER: cover property (q.state == OCG_SHUT ##[1:50] q.state == OCG_RUN);

endmodule : ocg_bridge

//--- ocg_top.sv
/*
 * half-bridge overcurrent guard: four independent protection slices,
 * pin synchronisers, trip-level lookup and the shutdown flag.
 * assumes the current samples come from an on-chip converter on clk,
 * and that pwm, clear, mode and short pins are asynchronous.
 */
// How it works
// - mode pin picks per-cycle or latched protection
// - each bridge keeps its own protection state
// - low-side trip kills both switches till period
// - high-side trip kills both switches till period
// - hard short latches floating shutdown in per-cycle mode
// - static input after trip leaves output floating
// - latched mode: any overcurrent shuts immediately
// - resistor value selects trip level by table
// - rising pair clear releases that pair's shutdown
// - any shutdown drives flag low
`timescale 1ns/1ps

module ocg_top
	import ocg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// pins from the controller
	input wire logic [3:0] pwm_in,
	input wire logic first_pair_clear_n,
	input wire logic second_pair_clear_n,
	input wire logic latched_trip_mode,
	// detector inputs
	input wire logic [3:0] short_det,
	input wire logic [7:0] trip_level_set_pin,
	input wire logic [3:0][7:0] hs_current_da,
	input wire logic [3:0][7:0] ls_current_da,
	// power stage drive
	output logic [3:0] hs_gate,
	output logic [3:0] ls_gate,
	output logic [3:0] out_hiz,
	// status
	output logic shutdown_flag_n,
	output logic [7:0] trip_level_da
);

	ocg_top_st_t q;
	ocg_top_st_t d;
	logic [`OCG_PIN_W-1:0] pins;
	logic [`OCG_PIN_W-1:0] agree;
	logic [3:0] pwm_f;
	logic [1:0] clr_f;
	logic [1:0] clr_rise;
	logic [3:0] short_f;
	logic latched_f;
	logic per_cycle_limit_mode;
	logic [3:0] shut_w;

	// ****************************************
	// trip lookup
	// ****************************************
	// larger resistors give lower levels; between table points the
	// lower level is taken so the guard never trips late
	function automatic logic [7:0] ocg_trip_lookup(input logic [7:0] r);
		logic [7:0] lvl;
		lvl = `OCG_LVL_36K;
		if (r <= `OCG_RES_22K) begin
			lvl = `OCG_LVL_22K;
		end else if (r <= `OCG_RES_24K) begin
			lvl = `OCG_LVL_24K;
		end else if (r <= `OCG_RES_27K) begin
			lvl = `OCG_LVL_27K;
		end else if (r <= `OCG_RES_30K) begin
			lvl = `OCG_LVL_30K;
		end
		return lvl;
	endfunction : ocg_trip_lookup

	// ****************************************
	// pin synchronisers
	// ****************************************
	assign pins = {short_det, latched_trip_mode, second_pair_clear_n, first_pair_clear_n,
		pwm_in};
	// a filtered bit moves only when stages two and three agree
	assign agree = ~(q.s2 ^ q.s3);

	always_comb begin
		d = q;
		if (clk_en) begin
			d.s1 = pins;
			d.s2 = q.s1;
			d.s3 = q.s2;
			d.filt = (q.s2 & agree) | (q.filt & ~agree);
			d.clr_prev = clr_f;
			d.trip = ocg_trip_lookup(trip_level_set_pin);
			d.fault_n = ~(|shut_w);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '{s1: `OCG_PIN_RESET, s2: `OCG_PIN_RESET, s3: `OCG_PIN_RESET,
				filt: `OCG_PIN_RESET, clr_prev: 2'h0, trip: `OCG_LVL_RESET, fault_n: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign pwm_f = q.filt[`OCG_PIN_PWM +: 4];
	assign clr_f = q.filt[`OCG_PIN_CLR +: 2];
	assign latched_f = q.filt[`OCG_PIN_LAT];
	assign short_f = q.filt[`OCG_PIN_SHORT +: 4];
	assign per_cycle_limit_mode = ~latched_f;
	// the controller pulses the clear only once the fault is gone; an
	// early pulse is ignored and a cause still present keeps the slice shut
	assign clr_rise = clr_f & ~q.clr_prev;

	// ****************************************
	// bridge slices
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < `OCG_NUM_BRIDGES; i++) begin : g_br
			ocg_bridge_if bif();

			assign bif.pwm = pwm_f[i];
			// the table value is the most current still carried, so trip above it
			assign bif.hs_oc = hs_current_da[i] > q.trip;
			assign bif.ls_oc = ls_current_da[i] > q.trip;
			// short path is the second detector, only apart in per-cycle mode
			assign bif.short_det = short_f[i] & per_cycle_limit_mode;
			assign bif.latched = ~per_cycle_limit_mode;
			assign bif.clear_low = ~clr_f[i/2];
			assign bif.clear_rise = clr_rise[i/2];

			ocg_bridge u_bridge (
				.clk(clk),
				.reset(reset),
				.clk_en(clk_en),
				.bus(bif.bridge)
			);

			assign hs_gate[i] = bif.hs_gate;
			assign ls_gate[i] = bif.ls_gate;
			assign out_hiz[i] = bif.hiz;
			assign shut_w[i] = bif.shut;
		end
	endgenerate

	assign shutdown_flag_n = q.fault_n;
	assign trip_level_da = q.trip;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// ****************************************
	// flag and trip level
	// ****************************************
	AST_FLAG: assert property (
		clk_en && (|shut_w) |=> !shutdown_flag_n
	) else $error("shutdown not flagged");
	AST_FLAG_CLR: assert property (
		clk_en && !(|shut_w) |=> shutdown_flag_n
	) else $error("flag held without shutdown");
	AST_TRIP22: assert property (
		clk_en && trip_level_set_pin <= `OCG_RES_22K |=> trip_level_da == `OCG_LVL_22K
	) else $error("wrong trip level at table start");
	AST_TRIP27: assert property (
		clk_en && trip_level_set_pin == `OCG_RES_27K |=> trip_level_da == `OCG_LVL_27K
	) else $error("wrong trip level");
	AST_TRIP36: assert property (
		clk_en && trip_level_set_pin > `OCG_RES_30K |=> trip_level_da == `OCG_LVL_36K
	) else $error("wrong trip level above table");

	// ****************************************
	// leg safety and independence
	// ****************************************
	AST_NO_SHOOT: assert property (
		!(|(hs_gate & ls_gate))
	) else $error("both switches of a leg on");
	AST_HIZ_OFF: assert property (
		!(|(out_hiz & (hs_gate | ls_gate)))
	) else $error("floating leg still switched");
	// a quiet neighbour stays out of shutdown
	AST_INDEP: assert property (
		clk_en && shut_w[0] && !shut_w[1] && !short_f[1] && !latched_f
		&& hs_current_da[1] <= q.trip && ls_current_da[1] <= q.trip |=> !shut_w[1]
	) else $error("trip spread to neighbour");
	AST_PER_CYCLE_LIM: assert property (
		clk_en && !latched_f && !short_f[0] && ls_current_da[0] > q.trip && !shut_w[0]
		|=> !shut_w[0] && out_hiz[0]
	) else $error("per-cycle trip latched or left leg driven");

	// ****************************************
	// pair clears and mode pin
	// ****************************************
	// a low pair clear floats both legs of its pair one edge later
	AST_PAIR0_OFF: assert property (
		clk_en && !clr_f[0] |=> out_hiz[1:0] == 2'b11
	) else $error("first pair drives while clear low");
	AST_PAIR1_OFF: assert property (
		clk_en && !clr_f[1] |=> out_hiz[3:2] == 2'b11
	) else $error("second pair drives while clear low");
	// the mode only moves once filter stages two and three agree
	AST_MODE_SYNC: assert property (
		clk_en && q.s2[`OCG_PIN_LAT] != q.s3[`OCG_PIN_LAT] |=> $stable(latched_f)
	) else $error("mode pin moved before the filter agreed");
	AST_LAT_SHUT: assert property (
		clk_en && latched_f && ls_current_da[1] > q.trip |=> shut_w[1]
	) else $error("latched mode left bridge one running");

	// ****************************************
	// scenarios
	// ****************************************
	COV_FLAG: cover property (!shutdown_flag_n ##[1:100] shutdown_flag_n);
	COV_LAT: cover property (latched_f && !shutdown_flag_n ##[1:200] shutdown_flag_n);

endmodule : ocg_top

//--- ocg_pwm_ctrl.sv
/*
 * controller model: drives the four pwm pins of the guard.
 * assumes one clock shared with the guard, reset active high.
 */
`timescale 1ns/1ps

module ocg_pwm_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control from the bench
	input wire logic [3:0] toggle_en,
	// pins to the guard
	output logic [3:0] pwm
);
	logic [2:0] cnt_q;

	// only toggling restores a floating output after a limit event
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= 3'h0;
			pwm <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			if (cnt_q == 3'h7) begin
				pwm <= pwm ^ toggle_en;
			end
		end
	end
endmodule : ocg_pwm_ctrl

//--- ocg_top_tb_top.sv
/*
 * self-checking bench of the overcurrent guard top.
 * assumes ocg_pkg, ocg_regs.svh and the controller model are compiled first.
 */
`timescale 1ns/1ps

module ocg_top_tb_top;
	import ocg_pkg::*;
	logic clk = 0;
	logic reset = 1;
	logic [3:0] tog = 4'h0;
	logic [3:0] pwm;
	logic clr_a_n = 0;
	logic clr_b_n = 0;
	logic lat = 0;
	logic [3:0] short = 4'h0;
	logic [7:0] res = 8'h1B;
	logic [3:0][7:0] hs = '0;
	logic [3:0][7:0] ls = '0;
	logic [3:0] hs_g, ls_g, hiz;
	logic flag_n;
	logic [7:0] lvl;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;

	always #50 clk = ~clk;

	ocg_pwm_ctrl u_ocg_pwm_ctrl (.clk(clk), .reset(reset), .toggle_en(tog), .pwm(pwm));
	ocg_top u_ocg_top (.clk(clk), .reset(reset), .clk_en(1'b1), .pwm_in(pwm),
		.first_pair_clear_n(clr_a_n), .second_pair_clear_n(clr_b_n),
		.latched_trip_mode(lat), .short_det(short), .trip_level_set_pin(res),
		.hs_current_da(hs), .ls_current_da(ls), .hs_gate(hs_g), .ls_gate(ls_g),
		.out_hiz(hiz), .shutdown_flag_n(flag_n), .trip_level_da(lvl));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// bounded poll, then one judged compare
	task automatic wait_hiz(input int b, input logic v);
		int n;
		for (n = 0; n < 40 && hiz[b] !== v; n++) @(negedge clk);
		check(hiz[b], v);
	endtask : wait_hiz

	// pulse low then high, longer than the pin filter
	task automatic pulse_clear(input int pair);
		@(posedge clk);
		if (pair == 0) begin
			clr_a_n <= 1'b0;
		end else begin
			clr_b_n <= 1'b0;
		end
		repeat (6) @(posedge clk);
		if (pair == 0) begin
			clr_a_n <= 1'b1;
		end else begin
			clr_b_n <= 1'b1;
		end
	endtask : pulse_clear

	task automatic t_trip_table();
		logic [7:0] r [5] = '{8'h16, 8'h18, 8'h1B, 8'h1E, 8'h24};
		logic [7:0] e [5] = '{8'h74, 8'h6B, 8'h61, 8'h58, 8'h4A};
		for (int i = 0; i < 5; i++) begin
			@(posedge clk) res <= r[i];
			repeat (2) @(negedge clk);
			check(lvl, e[i]);
		end
		@(posedge clk) res <= 8'h1B;
	endtask : t_trip_table

	task automatic t_low_side_limit();
		@(negedge clk);
		check(ls_g[0], 1);
		@(posedge clk) ls[0] <= 8'hFF;
		wait_hiz(0, 1);
		check(ls_g[0], 0);
		check(hiz[1], 0);
		@(posedge clk) ls[0] <= 8'h00;
		repeat (12) @(negedge clk);
		check(hiz[0], 1);
		check(flag_n, 1);
		@(posedge clk) tog[0] <= 1;
		wait_hiz(0, 0);
	endtask : t_low_side_limit

	task automatic t_high_side_limit();
		int n;
		@(posedge clk) tog[3] <= 1;
		for (n = 0; n < 40 && pwm[3] !== 1; n++) @(posedge clk);
		// the high switch follows the pin once the filter has passed it
		repeat (5) @(negedge clk);
		check(hs_g[3], 1);
		@(posedge clk) hs[3] <= 8'hFF;
		wait_hiz(3, 1);
		check(hs_g[3], 0);
		@(posedge clk) hs[3] <= 8'h00;
		wait_hiz(3, 0);
	endtask : t_high_side_limit

	task automatic t_short_latch();
		@(posedge clk) short[2] <= 1;
		wait_hiz(2, 1);
		repeat (3) @(negedge clk);
		check(flag_n, 0);
		@(posedge clk) short[2] <= 0;
		tog[2] <= 1;
		repeat (30) @(negedge clk);
		check(hiz[2], 1);
		pulse_clear(1);
		wait_hiz(2, 0);
		repeat (3) @(negedge clk);
		check(flag_n, 1);
	endtask : t_short_latch

	task automatic t_latched_mode();
		@(posedge clk) lat <= 1;
		repeat (5) @(posedge clk);
		ls[1] <= 8'hFF;
		wait_hiz(1, 1);
		repeat (3) @(negedge clk);
		check(flag_n, 0);
		@(posedge clk) ls[1] <= 8'h00;
		tog[1] <= 1;
		repeat (30) @(negedge clk);
		check(hiz[1], 1);
		pulse_clear(0);
		wait_hiz(1, 0);
	endtask : t_latched_mode

	// hang guard, well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		reset <= 0;
		@(negedge clk);
		check(hiz, 4'hF);
		check(flag_n, 1);
		check(lvl, 8'h4A);
		@(posedge clk) clr_a_n <= 1;
		clr_b_n <= 1;
		repeat (6) @(posedge clk);
		t_trip_table();
		t_low_side_limit();
		t_high_side_limit();
		t_short_latch();
		t_latched_mode();
		report_and_stop();
	end
endmodule : ocg_top_tb_top
